// >>> common/dpc_pkg.sv
package dpc_pkg;

    // ****************************************************************
    // Clock and pin timing
    // ****************************************************************
    localparam int CLK_MHZ       = 20;
    localparam int T_ADDR_SET_NS = 10;   // Address setup before the write strobe
    localparam int T_ACCESS_NS   = 70;   // Address/select to read data
    localparam int T_WPULSE_NS   = 40;   // Write strobe width
    localparam int T_ARB_NS      = 45;   // Longest arbitration time of the master
    localparam int T_HOLD_NS     = 5;    // Strobe kept past wait-flag release
    localparam int T_RDDLY_NS    = 70;   // Write-to-read data propagation

    // Least time, rounded up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CYC_ACCESS = ns_to_cyc(T_ACCESS_NS);
    localparam int CYC_WPULSE = ns_to_cyc(T_WPULSE_NS);
    localparam int CYC_ARB    = ns_to_cyc(T_ARB_NS);
    localparam int CYC_HOLD   = ns_to_cyc(T_HOLD_NS);
    localparam int CYC_RDDLY  = ns_to_cyc(T_RDDLY_NS);
    localparam int CYC_SETUP  = ns_to_cyc(T_ADDR_SET_NS);

    // ****************************************************************
    // Memory geometry
    // ****************************************************************
    localparam int ADDR_W     = 14;
    localparam int DATA_W     = 8;
    localparam int TIMER_W    = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WRITE,
        ST_READ,
        ST_WAIT,
        ST_HOLD,
        ST_RECOVER
    } dpc_state_t;

endpackage

// >>> rtl/dpc_timer.sv
`timescale 1ns/1ps
module dpc_timer
    import dpc_pkg::*;
#(
    parameter int WIDTH = TIMER_W
)(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_val_i,
    output logic      [WIDTH-1:0] count_o,
    output logic                  zero_o
);

    // A one-bit counter could not hold the shortest access plus its arbitration window
    if (WIDTH < 2)
        $error("dpc_timer: WIDTH too small");

    logic [WIDTH-1:0] cnt_ff;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_ff <= '0;
        else if (load_i)
            cnt_ff <= load_val_i;
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end

    assign count_o = cnt_ff;
    assign zero_o  = (cnt_ff == '0);

endmodule // dpc_timer

// >>> rtl/dpc_port_ctrl.sv
`timescale 1ns/1ps
module dpc_port_ctrl
    import dpc_pkg::*;
#(
    parameter bit SMALL_OPTION = 1'b0     // 8K-word part: top address bit held low
)(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    // User side
    input  wire logic              req_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic                   ready_o,
    output logic                   done_o,
    output logic [DATA_W-1:0]      rdata_o,
    // Memory port pins
    output logic                   sel_n_o,
    output logic                   rw_o,
    output logic                   oe_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              wait_n_i,
    output logic                   slave_we_n_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CYC_WPULSE + CYC_ARB > (1 << TIMER_W) - 1 || CYC_ACCESS > (1 << TIMER_W) - 1
        || CYC_RDDLY > (1 << TIMER_W) - 1 || CYC_SETUP != 1)
        $error("dpc_port_ctrl: timing counts do not fit the timer");

    localparam logic [TIMER_W-1:0] LD_WRITE = TIMER_W'(CYC_WPULSE + CYC_ARB);
    localparam logic [TIMER_W-1:0] LD_WPUL  = TIMER_W'(CYC_WPULSE);
    localparam logic [TIMER_W-1:0] LD_READ  = TIMER_W'(CYC_ACCESS);
    localparam logic [TIMER_W-1:0] LD_HOLD  = TIMER_W'(CYC_HOLD);
    localparam logic [TIMER_W-1:0] LD_RDDLY = TIMER_W'(CYC_RDDLY);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ****************************************************************
    // Timer
    // ****************************************************************
    dpc_state_t       state_ff;
    logic             we_ff;
    logic             tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic [TIMER_W-1:0] tmr_cnt;
    logic             tmr_zero;

    always_comb
    begin
        tmr_load = 1'b0;
        tmr_val  = '0;
        unique case (state_ff)
            ST_SETUP:
            begin
                tmr_load = 1'b1;
                tmr_val  = we_ff ? LD_WRITE : LD_READ;
            end
            ST_WAIT:
            begin
                tmr_load = wait_n_i;
                tmr_val  = we_ff ? LD_HOLD : LD_RDDLY;
            end
            ST_IDLE, ST_WRITE, ST_READ, ST_HOLD, ST_RECOVER:
            begin
                tmr_load = 1'b0;
            end
        endcase
    end

    dpc_timer #(
        .WIDTH      (TIMER_W)
    ) u_timer (
        .clk_i      (clk_i),
        .rstn_i     (rst_sync_ff),
        .load_i     (tmr_load),
        .load_val_i (tmr_val),
        .count_o    (tmr_cnt),
        .zero_o     (tmr_zero)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            state_ff <= ST_IDLE;
        else
        begin
            unique case (state_ff)
                ST_IDLE:    if (req_i) state_ff <= ST_SETUP;
                ST_SETUP:   state_ff <= we_ff ? ST_WRITE : ST_READ;
                // A low wait flag means our access lost; park and retry on release
                ST_WRITE:   if (!wait_n_i) state_ff <= ST_WAIT;
                            else if (tmr_zero) state_ff <= ST_RECOVER;
                ST_READ:    if (!wait_n_i) state_ff <= ST_WAIT;
                            else if (tmr_zero) state_ff <= ST_RECOVER;
                ST_WAIT:    if (wait_n_i) state_ff <= ST_HOLD;
                ST_HOLD:    if (tmr_zero) state_ff <= ST_RECOVER;
                ST_RECOVER: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Request capture: held stable for the whole access
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            we_ff   <= 1'b0;
            addr_o  <= '0;
            data_o  <= '0;
        end
        else if (state_ff == ST_IDLE && req_i)
        begin
            we_ff  <= we_i;
            addr_o <= SMALL_OPTION ? {1'b0, addr_i[ADDR_W-2:0]} : addr_i;
            data_o <= wdata_i;
        end
    end

    // ****************************************************************
    // Pin strobes
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            sel_n_o   <= 1'b1;
            rw_o      <= 1'b1;
            oe_n_o    <= 1'b1;
            data_oe_o <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    rw_o <= 1'b1;
                    if (req_i)
                        sel_n_o <= 1'b0;
                end
                ST_SETUP:
                begin
                    if (we_ff)
                    begin
                        rw_o      <= 1'b0;
                        data_oe_o <= 1'b1;
                    end
                    else
                        oe_n_o <= 1'b0;
                end
                ST_WRITE, ST_HOLD:
                begin
                    if (tmr_zero && (state_ff == ST_HOLD || wait_n_i))
                    begin
                        rw_o   <= 1'b1;
                        oe_n_o <= 1'b1;
                    end
                end
                ST_READ:
                begin
                    if (tmr_zero && wait_n_i)
                        oe_n_o <= 1'b1;
                end
                ST_WAIT:
                begin
                    sel_n_o <= 1'b0;
                end
                ST_RECOVER:
                begin
                    sel_n_o   <= 1'b1;
                    data_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Slave write strobe
    // ****************************************************************
    // Starts only after the master could have flagged us, so a lost race never
    // reaches the slaves; it is dropped on the next clock edge while the flag is low.
    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            slave_we_n_o <= 1'b1;
        else if (state_ff == ST_WRITE && wait_n_i && !tmr_zero && tmr_cnt <= LD_WPUL)
            slave_we_n_o <= 1'b0;
        else if (state_ff == ST_HOLD && we_ff && !tmr_zero)
            slave_we_n_o <= 1'b0;
        else
            slave_we_n_o <= 1'b1;
    end

    // ****************************************************************
    // User answers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            rdata_o <= '0;
            done_o  <= 1'b0;
            ready_o <= 1'b0;
        end
        else
        begin
            done_o  <= (state_ff == ST_RECOVER);
            ready_o <= (state_ff == ST_IDLE && !req_i) || (state_ff == ST_RECOVER);
            if (!we_ff && tmr_zero && wait_n_i && (state_ff == ST_READ || state_ff == ST_HOLD))
                rdata_o <= data_i;
        end
    end

endmodule // dpc_port_ctrl

// >>> tb/dpc_mem_model.sv
`timescale 1ns/1ps
module dpc_mem_model
    import dpc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sel_n_i,
    input  wire logic              rw_i,
    input  wire logic              oe_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              data_oe_i,
    input  wire logic              contend_i,
    input  wire logic [ADDR_W-1:0] far_addr_i,
    output logic      [DATA_W-1:0] data_o,
    output logic                   wait_n_o
);
    // ****************************************************************
    // One port of the array
    // ****************************************************************
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] last_ff = 8'h00;

    logic              far_own_ff = 1'b0;
    logic              hit;

    // Same cell on both ports while we are selected
    assign hit = contend_i && !sel_n_i && (addr_i == far_addr_i);
    // Whoever got to the cell first keeps it; a whole cycle is just beyond the arbitration window
    always @(posedge clk_i)
        far_own_ff <= contend_i && (far_own_ff || !hit);

    // Only the later port is flagged; the flag rises as the far port lets go; pulled high otherwise
    assign wait_n_o = !(hit && far_own_ff);

    always @(posedge clk_i)
        if (!sel_n_i && !rw_i && data_oe_i && wait_n_o) mem[addr_i] <= data_i;

    always @(posedge clk_i)
        last_ff <= data_o;

    // Released lines toggle so a stale byte can never pass for read data
    always_comb
        if (!sel_n_i && rw_i && !oe_n_i && wait_n_o) data_o = mem[addr_i];
        else data_o = ~last_ff;
endmodule // dpc_mem_model

// >>> tb/dpc_port_ctrl_chk.sv
`timescale 1ns/1ps
module dpc_port_ctrl_chk
    import dpc_pkg::*;
#(
    parameter bit SMALL_OPTION = 1'b0
)(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              done_o,
    input  wire logic              sel_n_o,
    input  wire logic              rw_o,
    input  wire logic              oe_n_o,
    input  wire logic [ADDR_W-1:0] addr_o,
    input  wire logic [DATA_W-1:0] data_o,
    input  wire logic              data_oe_o,
    input  wire logic              wait_n_i,
    input  wire logic              slave_we_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    chk_wait_holds_pins: assert property (
        !wait_n_i && (!rw_o || !oe_n_o) |=> $stable(addr_o) && $stable(data_o) && $stable(rw_o))
        else $error("pins moved while waiting");
    chk_slave_wait_off: assert property (
        !wait_n_i [*2] |-> slave_we_n_o) else $error("slave strobe during wait");
    chk_slave_arb_delay: assert property (
        $fell(rw_o) |-> slave_we_n_o) else $error("slave strobe not delayed");
    chk_hold_past_release: assert property (
        $rose(wait_n_i) && !rw_o |=> !rw_o) else $error("strobe dropped at release");
    chk_slave_after_release: assert property (
        $rose(wait_n_i) && !rw_o |-> ##[1:3] !slave_we_n_o) else $error("no slave write after release");
    chk_read_rw_high: assert property (
        !oe_n_o |-> rw_o && !sel_n_o) else $error("read without rw high");
    chk_addr_move_rw: assert property (
        $changed(addr_o) |-> rw_o) else $error("address moved in write");
    chk_slave_in_write: assert property (
        !slave_we_n_o |-> !rw_o && !sel_n_o && data_oe_o) else $error("slave strobe outside write");
    chk_no_bus_fight: assert property (
        data_oe_o |-> oe_n_o) else $error("data driven with output enable on");
    chk_top_bit_zero: assert property (
        SMALL_OPTION |-> !addr_o[ADDR_W-1]) else $error("top address bit set");

    cover property (!wait_n_i && !rw_o);
    cover property (!wait_n_i && !oe_n_o);
    cover property (done_o);
endmodule // dpc_port_ctrl_chk

bind dpc_port_ctrl dpc_port_ctrl_chk #(.SMALL_OPTION(SMALL_OPTION)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .done_o(done_o), .sel_n_o(sel_n_o), .rw_o(rw_o),
    .oe_n_o(oe_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .wait_n_i(wait_n_i), .slave_we_n_o(slave_we_n_o));

// >>> tb/dpc_port_ctrl_tb.sv
`timescale 1ns/1ps
module dpc_port_ctrl_tb;
    import dpc_pkg::*;
    logic              clk_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              req_i = 1'b0;
    logic              we_i = 1'b0;
    logic              contend = 1'b0;
    logic [ADDR_W-1:0] addr_i = 14'h0000;
    logic [DATA_W-1:0] wdata_i = 8'h00;
    logic              ready_o, done_o, sel_n_o, rw_o, oe_n_o, data_oe_o, wait_n, slave_we_n_o;
    logic [DATA_W-1:0] rdata_o, data_o, mem_data;
    logic [ADDR_W-1:0] addr_o;
    logic [ADDR_W-1:0] far_addr = 14'h0000;
    logic [ADDR_W-1:0] s_addr;
    int                lat = 0;
    logic [DATA_W-1:0] rd;
    int                n_mismatch = 0;
    int                check_count = 0;

    always #25 clk_i = ~clk_i;

    dpc_port_ctrl uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .sel_n_o(sel_n_o), .rw_o(rw_o),
        .oe_n_o(oe_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(mem_data),
        .wait_n_i(wait_n), .slave_we_n_o(slave_we_n_o));

    dpc_mem_model u_mem (
        .clk_i(clk_i), .sel_n_i(sel_n_o), .rw_i(rw_o), .oe_n_i(oe_n_o), .addr_i(addr_o),
        .data_i(data_o), .data_oe_i(data_oe_o), .contend_i(contend), .far_addr_i(far_addr), .data_o(mem_data),
        .wait_n_o(wait_n));

    // Second copy built for the 8K option, run in step with the first, to watch its top address bit
    dpc_port_ctrl #(.SMALL_OPTION(1'b1)) uut_small (
        .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .ready_o(), .done_o(), .rdata_o(), .sel_n_o(), .rw_o(), .oe_n_o(), .addr_o(s_addr), .data_o(),
        .data_oe_o(), .data_i(8'h00), .wait_n_i(1'b1), .slave_we_n_o());

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // One access; a nonzero stall makes the far port hold the cell
    // ****************************************************************
    task automatic access(input logic we, input logic [13:0] a, input logic [7:0] d, input int stall);
        @(negedge clk_i);
        req_i = 1'b1;
        we_i = we;
        addr_i = a;
        wdata_i = d;
        if (stall > 0)
        begin
            far_addr = a;
            contend = 1'b1;
        end
        @(negedge clk_i);
        req_i = 1'b0;
        if (stall > 0)
        begin
            repeat (stall) @(negedge clk_i);
            check("held addr", addr_o, a);
            check("held sel", sel_n_o, 1'b0);
            check("held rw", rw_o, !we);
            check("held oe", oe_n_o, we);
            check("slave off", slave_we_n_o, 1'b1);
            contend = 1'b0;
        end
        lat = 0;
        while (done_o !== 1'b1 && lat < 40)
        begin
            @(negedge clk_i);
            lat++;
        end
        check("done", done_o, 1'b1);
        rd = rdata_o;
        @(negedge clk_i);
        check("standby", sel_n_o, 1'b0 + 1'b1);
    endtask

    task automatic t_reset();
        check("rst sel", {sel_n_o, rw_o, oe_n_o, data_oe_o, slave_we_n_o}, 5'h1D);
        rstn_i = 1'b1;
        repeat (5) @(negedge clk_i);
        check("ready", ready_o, 1'b1);
    endtask

    // Every bank, at one end of its range: the bottom for even banks, the top for odd ones
    task automatic t_banks();
        logic [13:0] a;
        for (int b = 0; b < 8; b++)
        begin
            a = {b[2:0], b[0] ? 11'h7FF : 11'h000};
            access(1'b1, a, 8'h5A ^ (8'h11 * b[7:0]), 0);
            check("small top bit", s_addr, {1'b0, a[12:0]});
        end
        for (int b = 0; b < 8; b++)
        begin
            access(1'b0, {b[2:0], b[0] ? 11'h7FF : 11'h000}, 8'h00, 0);
            check("bank read", rd, 8'h5A ^ (8'h11 * b[7:0]));
        end
    endtask

    task automatic t_wait();
        access(1'b1, 14'h2AAA, 8'h3C, 0);
        access(1'b1, 14'h2AAA, 8'hC3, 5);
        access(1'b0, 14'h2AAA, 8'h00, 4);
        check("write after wait", rd, 8'hC3);
        // Far port busy on another cell: no flag, no extra cycles
        far_addr = 14'h3FFF;
        contend = 1'b1;
        access(1'b0, 14'h1000, 8'h00, 0);
        contend = 1'b0;
        check("no wait other cell", 16'(lat), 16'(3 + CYC_ACCESS));
        check("other cell", rd, 8'h5A ^ 8'h22);
        // Far port arrives on our cell after we hold it: we keep the grant
        fork
            access(1'b1, 14'h0800, 8'hA5, 0);
            begin
                repeat (2) @(negedge clk_i);
                far_addr = 14'h0800;
                contend = 1'b1;
            end
        join
        contend = 1'b0;
        check("earlier port wins", 16'(lat), 16'(3 + CYC_WPULSE + CYC_ARB));
        access(1'b0, 14'h0800, 8'h00, 0);
        check("winner wrote", rd, 8'hA5);
    endtask

    initial
    begin
        repeat (20) @(negedge clk_i);
        t_reset();
        t_banks();
        t_wait();
        results();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        results();
    end
endmodule // dpc_port_ctrl_tb
